/* File: logic/tcm_pkg.sv */
// package: constants and types of the timer channel mode control block
`default_nettype none
package tcm_pkg;
	localparam int NCH = 3;
	localparam int CVW = 16;
	localparam int NPS = 5;
	localparam int PS_STEP = 2;
	// address map: slot in addr[7:6], register in addr[5:0]
	localparam logic [1:0] SLOT_BLK = 2'h3;
	localparam logic [5:0] OFS_CMD = 6'h00;
	localparam logic [5:0] OFS_MODE = 6'h04;
	localparam logic [5:0] OFS_CV = 6'h10;
	localparam logic [5:0] OFS_RA = 6'h14;
	localparam logic [5:0] OFS_RB = 6'h18;
	localparam logic [5:0] OFS_RC = 6'h1C;
	localparam logic [5:0] OFS_STAT = 6'h20;
	localparam logic [5:0] OFS_ROUTE = 6'h04;
	localparam int HTRANS_ACT = 1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
	// field codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_SET = 2'h1;
	localparam logic [1:0] ACT_CLR = 2'h2;
	localparam logic [1:0] ACT_TOG = 2'h3;
	localparam logic [1:0] ROUTE_PIN = 2'h0;
	localparam logic [1:0] ROUTE_NONE = 2'h1;
	localparam logic [1:0] ROUTE_LO = 2'h2;
	localparam logic [1:0] ROUTE_HI = 2'h3;
	localparam logic [2:0] CLKS_XC0 = 3'h5;
	localparam logic [1:0] GATE_NONE = 2'h0;
	localparam logic [1:0] GATE_XC0 = 2'h1;
	localparam logic [1:0] EVT_LINE_B = 2'h0;
	localparam logic [1:0] EVT_XC0 = 2'h1;
	localparam int SHP_UPDN = 0;
	localparam int SHP_AUTO = 1;
	localparam logic [CVW-1:0] CV_MAX = 16'hFFFF;
	localparam logic [CVW-1:0] CV_ONE = 16'h0001;
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [28:0] rsv;
		logic soft_trigger_cmd;
		logic clock_disable_cmd;
		logic clock_enable_cmd;
	} tcm_cmd_s;
	typedef struct packed {
		logic [25:0] rsv;
		logic [1:0] ext_line2_route;
		logic [1:0] ext_line1_route;
		logic [1:0] ext_line0_route;
	} tcm_route_s;
	typedef struct packed {
		logic [11:0] rsv_hi;
		logic [1:0] b_load_edge;
		logic [1:0] a_load_edge;
		logic wave;
		logic c_match_trigger_enable;
		logic [2:0] rsv_mid;
		logic trigger_line_select;
		logic [1:0] trigger_edge_select;
		logic disable_on_b_load;
		logic stop_on_b_load;
		logic [1:0] burst;
		logic clock_invert;
		logic [2:0] clock_source_select;
	} tcm_cap_s;
	typedef struct packed {
		logic [1:0] soft_trigger_action_line_b;
		logic [1:0] event_action_line_b;
		logic [1:0] c_match_action_line_b;
		logic [1:0] b_match_action_line_b;
		logic [1:0] soft_trigger_action_line_a;
		logic [1:0] event_action_line_a;
		logic [1:0] c_match_action_line_a;
		logic [1:0] a_match_action_line_a;
		logic wave;
		logic [1:0] shape_select;
		logic event_trigger_enable;
		logic [1:0] event_source_select;
		logic [1:0] event_edge_select;
		logic disable_on_c_match;
		logic stop_on_c_match;
		logic [1:0] burst;
		logic clock_invert;
		logic [2:0] clock_source_select;
	} tcm_wav_s;
	typedef struct packed {
		logic [12:0] rsv_hi;
		logic mirror_b;
		logic mirror_a;
		logic clock_on;
		logic [15:0] rsv_lo;
	} tcm_stat_s;
	typedef struct packed {
		logic [31:0] mode;
		logic [CVW-1:0] cv;
		logic [CVW-1:0] ra;
		logic [CVW-1:0] rb;
		logic [CVW-1:0] rc;
		logic en;
		logic run;
		logic dn;
		logic ta;
		logic tb;
		logic a_oe;
		logic b_oe;
		logic pg;
		logic pa;
		logic pb;
		logic pe;
	} tcm_ch_s;
	typedef struct packed {
		logic hrdy;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_v;
		logic rd_v;
		logic [7:0] addr;
		tcm_route_s route;
		tcm_ch_s [NCH-1:0] ch;
	} tcm_st_s;
	localparam tcm_st_s ST_RST = '{hrdy: 1'b1, default: '0};
endpackage
`default_nettype wire

/* File: logic/tcm_prescaler.sv */
// divider: square-wave levels for the internal prescaled clocks
`default_nettype none
module tcm_prescaler #(
	parameter int NPS = tcm_pkg::NPS,
	parameter int STEP = tcm_pkg::PS_STEP
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	output logic [NPS-1:0] lvl
);
	import tcm_pkg::*;
	localparam int W = STEP * (NPS - 1) + 1;
	typedef struct packed {
		logic [W-1:0] cnt;
	} tcm_ps_s;
	tcm_ps_s st_r;
	tcm_ps_s st_nxt;

	// free-running count; level k is bit STEP*k, so each level is a clean square wave
	always_comb begin
		st_nxt = st_r;
		st_nxt.cnt = st_r.cnt + W'(1);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	for (genvar k = 0; k < NPS; k++) begin : g_lvl
		assign lvl[k] = st_r.cnt[STEP * k];
	end
endmodule
`default_nettype wire

/* File: logic/tcm_top.sv */
// top: AHB-Lite register slave, external clock routing and three timer channels
//
// Notes on behaviour
// - external line 0 routes pin 0, nothing, channel 1 line A or channel 2 line A
// - external line 1 routes pin 1, nothing, channel 0 line A or channel 2 line A
// - external line 2 routes pin 2, nothing, channel 0 line A or channel 1 line A
// - command enable bit starts the clock unless disable is also written or a disable on C match or B load fires in that cycle
// - command disable bit stops the clock and beats a simultaneous enable
// - command soft trigger bit resets the count and starts the clock
// - source field picks five prescaled clocks or three external lines; invert picks falling
// - gating field ANDs the chosen clock with external line 0, 1 or 2
// - capture: stop-on-B-load stops the clock when hold B loads
// - capture: disable-on-B-load disables the clock when hold B loads
// - capture: trigger from line A or B with none, rising, falling, each edge
// - capture: C match trigger bit makes a C match reset and restart the count
// - mode bit 15 picks capture at zero and waveform at one
// - waveform: C match stops and/or disables the clock per two bits
// - waveform: event source line B, or line 0..2; line B output otherwise
// - waveform: event trigger bit lets the event reset and restart the count
// - shape field: up with or without C match trigger, or up-down turning at hold C or at all ones
// - waveform: event edge none, rising, falling or each edge
// - line A reacts to A match, C match, event, soft trigger by set/clear/toggle
// - line B reacts to B match, C match, event, soft trigger likewise
// - hold A and B writable by software only in waveform mode
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`default_nettype none
module tcm_top #(
	parameter int PS_STEP = tcm_pkg::PS_STEP
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [tcm_pkg::NCH-1:0] clock_input_pin,
	input wire logic [tcm_pkg::NCH-1:0] line_a_in,
	output logic [tcm_pkg::NCH-1:0] line_a_out,
	output logic [tcm_pkg::NCH-1:0] line_a_oe,
	input wire logic [tcm_pkg::NCH-1:0] line_b_in,
	output logic [tcm_pkg::NCH-1:0] line_b_out,
	output logic [tcm_pkg::NCH-1:0] line_b_oe
);
	import tcm_pkg::*;

	tcm_st_s st_r;
	tcm_st_s st_nxt;
	logic [NPS-1:0] ps_lvl;
	logic [NCH-1:0] xc;
	logic [NCH-1:0] la;
	logic [NCH-1:0] lb;
	logic [NCH-1:0] tick_w;
	logic [NCH-1:0] trig_w;
	logic [NCH-1:0] cc_w;
	logic [NCH-1:0] lda_w;
	logic [NCH-1:0] ldb_w;
	logic [NCH-1:0] sw_w;
	logic [NCH-1:0] en_w;
	logic [NCH-1:0] dis_w;
	logic [31:0] rd_mux;
	logic [1:0] slot;
	logic [5:0] ofs;
	logic acc;
	logic wrc;
	logic wave;
	logic lvl;
	logic gate;
	logic src;
	logic ev;
	logic hit_a;
	logic hit_b;
	logic stop;
	logic kill;
	logic up_dir;
	logic [CVW-1:0] top_v;
	tcm_cmd_s cmd;
	tcm_cap_s cp;
	tcm_wav_s wv;
	tcm_stat_s sr;

	////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic route_pick(input logic [1:0] sel, input logic pin, input logic a_lo,
		input logic a_hi);
		unique case (sel)
			ROUTE_PIN: return pin;
			ROUTE_NONE: return 1'b0;
			ROUTE_LO: return a_lo;
			ROUTE_HI: return a_hi;
		endcase
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
		unique case (sel)
			EDGE_NONE: return 1'b0;
			EDGE_RISE: return cur && !prv;
			EDGE_FALL: return !cur && prv;
			EDGE_BOTH: return cur ^ prv;
		endcase
	endfunction

	function automatic logic act(input logic [1:0] code, input logic hit, input logic cur);
		if (!hit) begin
			return cur;
		end
		unique case (code)
			ACT_NONE: return cur;
			ACT_SET: return 1'b1;
			ACT_CLR: return 1'b0;
			ACT_TOG: return !cur;
		endcase
	endfunction

	tcm_prescaler #(
		.NPS(NPS),
		.STEP(PS_STEP)
	) u_ps (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.lvl(ps_lvl)
	);

	////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;
		slot = st_r.addr[7:6];
		ofs = st_r.addr[5:0];
		cmd = tcm_cmd_s'(hwdata);
		rd_mux = '0;
		sr = '0;
		tick_w = '0;
		trig_w = '0;
		cc_w = '0;
		lda_w = '0;
		ldb_w = '0;
		sw_w = '0;
		en_w = '0;
		dis_w = '0;
		wrc = 1'b0;
		wave = 1'b0;
		lvl = 1'b0;
		gate = 1'b0;
		src = 1'b0;
		ev = 1'b0;
		hit_a = 1'b0;
		hit_b = 1'b0;
		stop = 1'b0;
		kill = 1'b0;
		up_dir = 1'b0;
		top_v = '0;
		cp = '0;
		wv = '0;
		// pin level of each line: own drive when enabled, else the input
		for (int c = 0; c < NCH; c++) begin
			la[c] = st_r.ch[c].a_oe ? st_r.ch[c].ta : line_a_in[c];
			lb[c] = st_r.ch[c].b_oe ? st_r.ch[c].tb : line_b_in[c];
		end
		xc[0] = route_pick(st_r.route.ext_line0_route, clock_input_pin[0], la[1], la[2]);
		xc[1] = route_pick(st_r.route.ext_line1_route, clock_input_pin[1], la[0], la[2]);
		xc[2] = route_pick(st_r.route.ext_line2_route, clock_input_pin[2], la[0], la[1]);

		// read mux; unmapped offsets read zero
		if (slot == SLOT_BLK) begin
			if (ofs == OFS_ROUTE) begin
				rd_mux = st_r.route;
			end
		end else begin
			sr.clock_on = st_r.ch[slot].en;
			sr.mirror_a = la[slot];
			sr.mirror_b = lb[slot];
			unique case (ofs)
				OFS_MODE: rd_mux = st_r.ch[slot].mode;
				OFS_CV: rd_mux = 32'(st_r.ch[slot].cv);
				OFS_RA: rd_mux = 32'(st_r.ch[slot].ra);
				OFS_RB: rd_mux = 32'(st_r.ch[slot].rb);
				OFS_RC: rd_mux = 32'(st_r.ch[slot].rc);
				OFS_STAT: rd_mux = sr;
				default: rd_mux = '0;
			endcase
		end

		// bus: writes take no wait, reads one wait so a prior write is always seen
		st_nxt.hrdy = 1'b1;
		st_nxt.hresp = HRESP_OKAY;
		st_nxt.wr_v = 1'b0;
		st_nxt.rd_v = 1'b0;
		if (st_r.rd_v) begin
			st_nxt.hrdata = rd_mux;
		end
		acc = hsel && htrans[HTRANS_ACT] && hready;
		if (acc) begin
			st_nxt.addr = haddr[7:0];
			st_nxt.wr_v = hwrite && (hsize == SIZE_WORD);
			st_nxt.rd_v = !hwrite;
			st_nxt.hrdy = hwrite;
		end
		if (st_r.wr_v && slot == SLOT_BLK && ofs == OFS_ROUTE) begin
			st_nxt.route = tcm_route_s'(hwdata);
			st_nxt.route.rsv = '0;
		end

		for (int c = 0; c < NCH; c++) begin
			cp = tcm_cap_s'(st_r.ch[c].mode);
			wv = tcm_wav_s'(st_r.ch[c].mode);
			// one bit splits the mode register into two views
			wave = cp.wave;
			wrc = st_r.wr_v && (slot == 2'(c));
			if (wrc && ofs == OFS_MODE) begin
				st_nxt.ch[c].mode = hwdata;
			end
			if (wrc && ofs == OFS_RC) begin
				st_nxt.ch[c].rc = hwdata[CVW-1:0];
			end
			// hold A and B are read-only while capturing
			if (wrc && wave && ofs == OFS_RA) begin
				st_nxt.ch[c].ra = hwdata[CVW-1:0];
			end
			if (wrc && wave && ofs == OFS_RB) begin
				st_nxt.ch[c].rb = hwdata[CVW-1:0];
			end

			if (cp.clock_source_select < CLKS_XC0) begin
				lvl = ps_lvl[cp.clock_source_select];
			end else begin
				lvl = xc[2'(cp.clock_source_select - CLKS_XC0)];
			end
			// burst gating by an external line
			gate = (cp.burst == GATE_NONE) ? 1'b1 : xc[2'(cp.burst - GATE_XC0)];
			lvl = lvl && gate;
			st_nxt.ch[c].pg = lvl;
			tick_w[c] = st_r.ch[c].en && st_r.ch[c].run &&
				(cp.clock_invert ? (st_r.ch[c].pg && !lvl) : (!st_r.ch[c].pg && lvl));

			src = cp.trigger_line_select ? la[c] : lb[c];
			if (wave) begin
				src = (wv.event_source_select == EVT_LINE_B) ? lb[c] : xc[2'(wv.event_source_select - EVT_XC0)];
			end
			// edge of the event or trigger
			ev = edge_hit(wave ? wv.event_edge_select : cp.trigger_edge_select, src, st_r.ch[c].pe);
			st_nxt.ch[c].pe = src;
			st_nxt.ch[c].pa = la[c];
			st_nxt.ch[c].pb = lb[c];

			// compares act on a counting edge while the count sits on the hold value
			hit_a = tick_w[c] && st_r.ch[c].cv == st_r.ch[c].ra;
			hit_b = tick_w[c] && st_r.ch[c].cv == st_r.ch[c].rb;
			cc_w[c] = tick_w[c] && st_r.ch[c].cv == st_r.ch[c].rc;

			// capture loads on line A edges
			lda_w[c] = !wave && edge_hit(cp.a_load_edge, la[c], st_r.ch[c].pa);
			ldb_w[c] = !wave && edge_hit(cp.b_load_edge, la[c], st_r.ch[c].pa);
			if (lda_w[c]) begin
				st_nxt.ch[c].ra = st_r.ch[c].cv;
			end
			if (ldb_w[c]) begin
				st_nxt.ch[c].rb = st_r.ch[c].cv;
			end

			// all trigger sources merge into one reset
			sw_w[c] = wrc && ofs == OFS_CMD && cmd.soft_trigger_cmd;
			if (wave) begin
				trig_w[c] = sw_w[c] || (ev && wv.event_trigger_enable) ||
					(cc_w[c] && wv.shape_select[SHP_AUTO] && !wv.shape_select[SHP_UPDN]);
			end else begin
				trig_w[c] = sw_w[c] || ev || (cc_w[c] && cp.c_match_trigger_enable);
			end

			// count shape; up-down turns at the top and at zero
			top_v = wv.shape_select[SHP_AUTO] ? st_r.ch[c].rc : CV_MAX;
			if (trig_w[c]) begin
				st_nxt.ch[c].cv = '0;
				st_nxt.ch[c].dn = 1'b0;
				st_nxt.ch[c].run = 1'b1;
			end else if (tick_w[c]) begin
				if (wave && wv.shape_select[SHP_UPDN]) begin
					up_dir = st_r.ch[c].dn ? (st_r.ch[c].cv == '0) : (st_r.ch[c].cv != top_v);
					st_nxt.ch[c].dn = !up_dir;
					st_nxt.ch[c].cv = up_dir ? st_r.ch[c].cv + CV_ONE : st_r.ch[c].cv - CV_ONE;
				end else begin
					st_nxt.ch[c].cv = st_r.ch[c].cv + CV_ONE;
				end
			end

			stop = wave ? (cc_w[c] && wv.stop_on_c_match) : (ldb_w[c] && cp.stop_on_b_load);
			kill = wave ? (cc_w[c] && wv.disable_on_c_match) : (ldb_w[c] && cp.disable_on_b_load);
			if (stop) begin
				st_nxt.ch[c].run = 1'b0;
			end
			en_w[c] = wrc && ofs == OFS_CMD && cmd.clock_enable_cmd;
			dis_w[c] = (wrc && ofs == OFS_CMD && cmd.clock_disable_cmd) || kill;
			if (en_w[c] && !dis_w[c]) begin
				st_nxt.ch[c].en = 1'b1;
				st_nxt.ch[c].run = 1'b1;
			end
			if (dis_w[c]) begin
				st_nxt.ch[c].en = 1'b0;
				st_nxt.ch[c].run = 1'b0;
			end

			// line A actions; applied in order so the soft trigger wins
			if (wave) begin
				st_nxt.ch[c].ta = act(wv.a_match_action_line_a, hit_a, st_r.ch[c].ta);
				st_nxt.ch[c].ta = act(wv.c_match_action_line_a, cc_w[c], st_nxt.ch[c].ta);
				st_nxt.ch[c].ta = act(wv.event_action_line_a, ev, st_nxt.ch[c].ta);
				st_nxt.ch[c].ta = act(wv.soft_trigger_action_line_a, sw_w[c], st_nxt.ch[c].ta);
			end
			// line B actions, only while line B is an output
			if (wave && wv.event_source_select != EVT_LINE_B) begin
				st_nxt.ch[c].tb = act(wv.b_match_action_line_b, hit_b, st_r.ch[c].tb);
				st_nxt.ch[c].tb = act(wv.c_match_action_line_b, cc_w[c], st_nxt.ch[c].tb);
				st_nxt.ch[c].tb = act(wv.event_action_line_b, ev, st_nxt.ch[c].tb);
				st_nxt.ch[c].tb = act(wv.soft_trigger_action_line_b, sw_w[c], st_nxt.ch[c].tb);
			end
			// pin directions follow the mode about to take effect
			cp = tcm_cap_s'(st_nxt.ch[c].mode);
			wv = tcm_wav_s'(st_nxt.ch[c].mode);
			st_nxt.ch[c].a_oe = cp.wave;
			st_nxt.ch[c].b_oe = cp.wave && wv.event_source_select != EVT_LINE_B;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign hreadyout = st_r.hrdy;
	assign hrdata = st_r.hrdata;
	assign hresp = st_r.hresp;
	for (genvar g = 0; g < NCH; g++) begin : g_out
		assign line_a_out[g] = st_r.ch[g].ta;
		assign line_a_oe[g] = st_r.ch[g].a_oe;
		assign line_b_out[g] = st_r.ch[g].tb;
		assign line_b_oe[g] = st_r.ch[g].b_oe;
	end

	////////////////////////////////////////////////////////////////
	// checks on channel 0 and the bus

	tcm_cap_s cap0;
	tcm_wav_s wav0;
	assign cap0 = st_r.ch[0].mode;
	assign wav0 = st_r.ch[0].mode;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	route_none_a: assert property (st_r.route.ext_line0_route == ROUTE_NONE |-> !xc[0])
		else $error("unrouted line 0 not low");
	en_cmd_a: assert property (en_w[0] && !dis_w[0] |=> st_r.ch[0].en && st_r.ch[0].run)
		else $error("enable command ignored");
	dis_wins_a: assert property (dis_w[0] |=> !st_r.ch[0].en ##0 !st_r.ch[0].run)
		else $error("disable did not stop channel");
	sw_reset_a: assert property (sw_w[0] && !cc_w[0] && !ldb_w[0] && !dis_w[0] |=>
		st_r.ch[0].cv == '0 && st_r.ch[0].run) else $error("soft trigger missed");
	tick_step_a: assert property (tick_w[0] && !trig_w[0] && !cap0.wave |=>
		st_r.ch[0].cv == CVW'($past(st_r.ch[0].cv) + CV_ONE)) else $error("count step wrong");
	ldb_stop_a: assert property (ldb_w[0] && cap0.stop_on_b_load && !en_w[0] |=> !st_r.ch[0].run)
		else $error("B load did not stop clock");
	c_stop_a: assert property (cc_w[0] && wav0.wave && wav0.stop_on_c_match && !en_w[0] |=>
		!st_r.ch[0].run) else $error("C match did not stop clock");
	hold_ro_a: assert property (st_r.wr_v && slot == 2'h0 && ofs == OFS_RA && !cap0.wave && !lda_w[0]
		|=> $stable(st_r.ch[0].ra)) else $error("hold A written in capture");
	b_dir_a: assert property (line_b_oe[0] == (wav0.wave && wav0.event_source_select != EVT_LINE_B))
		else $error("line B direction wrong");
	sw_set_a: assert property (sw_w[0] && wav0.wave && wav0.soft_trigger_action_line_a == ACT_SET
		|=> line_a_out[0]) else $error("line A not set by soft trigger");
	// read answers after exactly one wait state
	rd_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	soft_trig_c: cover property (sw_w[0] && st_r.ch[0].en);
	c_stop_c: cover property (cc_w[0] && wav0.wave && wav0.stop_on_c_match);
	b_load_c: cover property (ldb_w[0]);
	ext_trig_c: cover property (trig_w[0] && !sw_w[0]);
endmodule
`default_nettype wire

/* File: tb/tcm_pin_model.sv */
// pin model: external clock pins and far-side drivers of the channel lines
`default_nettype none
module tcm_pin_model (
	input wire logic sys_clk,
	input wire logic [tcm_pkg::NCH-1:0] line_a_out,
	input wire logic [tcm_pkg::NCH-1:0] line_a_oe,
	input wire logic [tcm_pkg::NCH-1:0] line_b_out,
	input wire logic [tcm_pkg::NCH-1:0] line_b_oe,
	output logic [tcm_pkg::NCH-1:0] clock_input_pin,
	output logic [tcm_pkg::NCH-1:0] line_a_in,
	output logic [tcm_pkg::NCH-1:0] line_b_in
);
	import tcm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic [NCH-1:0] ext_a = '0;
	logic [NCH-1:0] ext_b = '0;
	initial clock_input_pin = '0;
	// a driven pin reads back its own level; otherwise the far side's level
	assign line_a_in = (line_a_oe & line_a_out) | (~line_a_oe & ext_a);
	assign line_b_in = (line_b_oe & line_b_out) | (~line_b_oe & ext_b);
	// far side drives line A of channel k to level v just after an edge
	task automatic set_a(input int k, input logic v);
		@(posedge sys_clk);
		ext_a[k] <= v;
		repeat (2) @(posedge sys_clk);
	endtask
	// n pulses on pin k, each level held hw cycles; the pin rests low between bursts
	task automatic pulses(input int k, input int n, input int hw);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge sys_clk);
			clock_input_pin[k] <= ~clock_input_pin[k];
			repeat (hw - 1) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench: registers, commands, clock routing and line actions of the timer block
`default_nettype none
module tb_top;
	import tcm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_CMD = {2'h0, OFS_CMD};
	localparam logic [7:0] A_MODE = {2'h0, OFS_MODE};
	localparam logic [7:0] A_CNT = {2'h0, OFS_CV};
	localparam logic [7:0] A_HA = {2'h0, OFS_RA};
	localparam logic [7:0] A_HB = {2'h0, OFS_RB};
	localparam logic [7:0] A_HC = {2'h0, OFS_RC};
	localparam logic [7:0] A_STAT = {2'h0, OFS_STAT};
	localparam logic [7:0] A_RTE = {SLOT_BLK, OFS_ROUTE};
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = SIZE_WORD;
	logic [31:0] hwdata = '0;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [NCH-1:0] pin, a_in, a_out, a_oe, b_in, b_out, b_oe;
	logic [31:0] q;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	initial forever #4 sys_clk = ~sys_clk;
	tcm_top u_tcm_top (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .clock_input_pin(pin), .line_a_in(a_in), .line_a_out(a_out),
		.line_a_oe(a_oe), .line_b_in(b_in), .line_b_out(b_out), .line_b_oe(b_oe));
	tcm_pin_model u_tcm_pin_model (.sys_clk(sys_clk), .line_a_out(a_out), .line_a_oe(a_oe),
		.line_b_out(b_out), .line_b_oe(b_oe), .clock_input_pin(pin), .line_a_in(a_in), .line_b_in(b_in));
	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: pin %b expected %b", $time, got, exp);
		end
	endtask
	// one single transfer; the address phase stands until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rdchk(A_MODE, 32'h0); // mode cleared
		bus(1'b1, A_RTE, 32'h3F);
		rdchk(A_RTE, 32'h3F); // routing kept
		rdchk(8'h08, 32'h0);
		rdchk(A_CMD, 32'h0); // command reads zero
		chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
		bus(1'b1, A_RTE, 32'h0);
	endtask
	task automatic t_cmd();
		logic [31:0] c[6] = '{32'h1, 32'h2, 32'h3, 32'h1, 32'h0, 32'h2};
		logic [31:0] e[6] = '{32'h10000, 32'h0, 32'h0, 32'h10000, 32'h10000, 32'h0};
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, A_CMD, c[i]);
			rdchk(A_STAT, e[i]); // clock state
		end
	endtask
	task automatic t_count();
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, A_MODE, 32'h5 + k);
			bus(1'b1, A_CMD, 32'h5);
			u_tcm_pin_model.pulses(k, 3, 2 + 3 * k);
			rdchk(A_CNT, 32'h3); // pin routed
		end
		bus(1'b1, A_CMD, 32'h4);
		rdchk(A_CNT, 32'h0); // trigger clears
		bus(1'b1, A_RTE, 32'h15);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, A_MODE, 32'h5 + k);
			bus(1'b1, A_CMD, 32'h5);
			u_tcm_pin_model.pulses(k, 3, 2);
			rdchk(A_CNT, 32'h0); // nothing routed
		end
		bus(1'b1, A_RTE, 32'h4);
		bus(1'b1, A_MODE, 32'h25);
		bus(1'b1, A_CMD, 32'h5);
		u_tcm_pin_model.pulses(0, 3, 2);
		rdchk(A_CNT, 32'h0); // gate held low
		bus(1'b1, A_MODE, 32'h15);
		bus(1'b1, A_CMD, 32'h5);
		u_tcm_pin_model.pulses(0, 3, 2);
		rdchk(A_CNT, 32'h3); // gate follows clock
		// fastest internal clock: one count every two cycles
		bus(1'b1, A_MODE, 32'h0);
		bus(1'b1, A_CMD, 32'h5);
		repeat (20) @(posedge sys_clk);
		bus(1'b0, A_CNT, 32'h0);
		chk({31'h0, q > 32'h8}, 32'h1); // internal clock counts
	endtask
	task automatic t_cmatch();
		bus(1'b1, A_RTE, 32'h0);
		bus(1'b1, A_HC, 32'h2);
		bus(1'b1, A_MODE, 32'h8045);
		bus(1'b1, A_CMD, 32'h5);
		u_tcm_pin_model.pulses(0, 5, 3);
		bus(1'b0, A_CNT, 32'h0);
		chk({31'h0, q < 32'h4}, 32'h1); // count halted
		rdchk(A_STAT, 32'h10000); // still enabled
		bus(1'b1, A_MODE, 32'h8085);
		bus(1'b1, A_CMD, 32'h5);
		u_tcm_pin_model.pulses(0, 5, 3);
		rdchk(A_STAT, 32'h0); // clock disabled
		for (int w = 0; w < 2; w++) begin
			bus(1'b1, A_MODE, 32'h4005 | (w << 15));
			bus(1'b1, A_CMD, 32'h5);
			u_tcm_pin_model.pulses(0, 5, 2);
			rdchk(A_CNT, 32'h2); // wraps after hold C
		end
	endtask
	task automatic t_hold();
		bus(1'b1, A_MODE, 32'h0);
		@(negedge sys_clk);
		chk_pin(a_oe[0], 1'b0); // line A released
		bus(1'b1, A_HA, 32'h1234);
		rdchk(A_HA, 32'h0); // write refused
		bus(1'b1, A_MODE, 32'h8000);
		bus(1'b1, A_HA, 32'h1234);
		rdchk(A_HA, 32'h1234); // write taken
	endtask
	task automatic t_lines();
		logic [31:0] md[3] = '{32'h40408000, 32'h40C08400, 32'h80C08400};
		logic [2:0] ex[3] = '{3'b100, 3'b011, 3'b110};
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, A_MODE, md[i]);
			bus(1'b1, A_CMD, 32'h4);
			bus(1'b0, A_MODE, 32'h0);
			chk_pin(a_oe[0], 1'b1); // line A driven
			chk_pin(a_out[0], ex[i][2]); // soft action on A
			chk_pin(b_oe[0], ex[i][1]); // line B direction
			if (ex[i][1]) chk_pin(b_out[0], ex[i][0]); // soft action on B
		end
	endtask
	// capture: hold A loads on rising line A, hold B on falling, B load stops the clock
	task automatic t_capture();
		bus(1'b1, A_MODE, 32'h00090045);
		bus(1'b1, A_CMD, 32'h5);
		u_tcm_pin_model.pulses(0, 2, 2);
		u_tcm_pin_model.set_a(0, 1'b1);
		u_tcm_pin_model.pulses(0, 1, 2);
		u_tcm_pin_model.set_a(0, 1'b0);
		u_tcm_pin_model.pulses(0, 2, 2);
		rdchk(A_HA, 32'h2); // load A on rising edge
		rdchk(A_HB, 32'h3); // load B on falling edge
		rdchk(A_CNT, 32'h3); // B load stopped clock
	endtask
	////////////////////////////////////////////////////////////////
	// cycle ceiling well above the few hundred cycles the scenarios need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_regs();
		t_cmd();
		t_count();
		t_cmatch();
		t_hold();
		t_lines();
		t_capture();
		conclude();
	end
endmodule
`default_nettype wire
